// File: src/tlv_irq_ctrl.sv
// Purpose: Enable, two-level priority and vectoring for eleven interrupt sources.
// Assumes: Source flags are levels held by their peripherals on clk_i.
// Notes: APB answers after one wait cycle; registers sit at index times four.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module tlv_irq_ctrl #(
  parameter int TMO_W = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Peripheral request flags
  input wire logic supply_mon_flag_i,
  input wire logic ext0_flag_i,
  input wire logic [1:0] conv_done_flags_i,
  input wire logic tmr0_ovf_flag_i,
  input wire logic ext1_flag_i,
  input wire logic tmr1_ovf_flag_i,
  input wire logic twowire_flag_i,
  input wire logic sync_port_flag_i,
  input wire logic uart_rx_flag_i,
  input wire logic uart_tx_flag_i,
  input wire logic tmr2_ovf_flag_i,
  input wire logic tmr2_ext_flag_i,
  input wire logic interval_ctr_flag_i,
  input wire logic wdog_timeout_i,
  // Core sequencer
  input wire logic boundary_i,
  input wire logic vec_ack_i,
  input wire logic reti_i,
  output tlv_pkg::tlv_vec_t vec_o,
  output logic wdog_rst_o,
  output logic irq_o
);

  // Software-visible registers
  logic [7:0] irq_en_reg;
  logic [7:0] aux_irq_en_lvl;
  logic [7:0] irq_level;
  logic [tlv_pkg::NUM_EV-1:0] ev_stat;
  logic [tlv_pkg::NUM_EV-1:0] ev_mask;
  logic wdog_irq_mode;
  logic [TMO_W-1:0] wdog_tmo;
  logic wdog_flag;
  // Active service levels
  logic act_hi;
  logic act_lo;
  // Arbiter
  tlv_pkg::tlv_state_t state;
  logic [tlv_pkg::NUM_SRC-1:0] src_req;
  logic [tlv_pkg::NUM_SRC-1:0] src_en;
  logic [tlv_pkg::NUM_SRC-1:0] src_hi;
  logic [tlv_pkg::NUM_SRC-1:0] elig_hi;
  logic [tlv_pkg::NUM_SRC-1:0] elig_lo;
  logic pick_valid;
  logic pick_hi;
  logic [15:0] pick_addr;
  // Bus strobes
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_val;
  logic rd_err;
  logic wdog_ev;
  logic take;

  // Completing write: the edge where the master sees pready
  assign wr_go = psel_i & penable_i & pready_o & pwrite_i;
  // First access cycle: prepare data and ready
  assign rd_go = psel_i & penable_i & ~pready_o;
  assign take = (state == tlv_pkg::ST_OFFER) & vec_ack_i;

  // Request gathering
  always_comb
  begin
    src_req = '0;
    src_req[tlv_pkg::SRC_SUPPLY] = supply_mon_flag_i;
    src_req[tlv_pkg::SRC_WDOG] = wdog_flag;
    src_req[tlv_pkg::SRC_EXT0] = ext0_flag_i;
    src_req[tlv_pkg::SRC_CONV] = |conv_done_flags_i;
    src_req[tlv_pkg::SRC_TMR0] = tmr0_ovf_flag_i;
    src_req[tlv_pkg::SRC_EXT1] = ext1_flag_i;
    src_req[tlv_pkg::SRC_TMR1] = tmr1_ovf_flag_i;
    src_req[tlv_pkg::SRC_SYNC] = twowire_flag_i | sync_port_flag_i;
    src_req[tlv_pkg::SRC_UART] = uart_rx_flag_i | uart_tx_flag_i;
    src_req[tlv_pkg::SRC_TMR2] = tmr2_ovf_flag_i | tmr2_ext_flag_i;
    src_req[tlv_pkg::SRC_ICTR] = interval_ctr_flag_i;
  end

  // Enable and level map per source
  always_comb
  begin
    src_en = '0;
    src_hi = '0;
    src_en[tlv_pkg::SRC_SUPPLY] = aux_irq_en_lvl[1];
    src_en[tlv_pkg::SRC_SYNC] = aux_irq_en_lvl[0];
    src_en[tlv_pkg::SRC_ICTR] = aux_irq_en_lvl[2];
    src_en[tlv_pkg::SRC_EXT0] = irq_en_reg[0];
    src_en[tlv_pkg::SRC_TMR0] = irq_en_reg[1];
    src_en[tlv_pkg::SRC_EXT1] = irq_en_reg[2];
    src_en[tlv_pkg::SRC_TMR1] = irq_en_reg[3];
    src_en[tlv_pkg::SRC_UART] = irq_en_reg[4];
    src_en[tlv_pkg::SRC_TMR2] = irq_en_reg[5];
    src_en[tlv_pkg::SRC_CONV] = irq_en_reg[6];
    src_en = src_en & {tlv_pkg::NUM_SRC{irq_en_reg[tlv_pkg::GLOBAL_EN_BIT]}};
    src_en[tlv_pkg::SRC_WDOG] = 1'b1;
    src_hi[tlv_pkg::SRC_SUPPLY] = aux_irq_en_lvl[5];
    src_hi[tlv_pkg::SRC_SYNC] = aux_irq_en_lvl[4];
    src_hi[tlv_pkg::SRC_ICTR] = aux_irq_en_lvl[6];
    src_hi[tlv_pkg::SRC_EXT0] = irq_level[0];
    src_hi[tlv_pkg::SRC_TMR0] = irq_level[1];
    src_hi[tlv_pkg::SRC_EXT1] = irq_level[2];
    src_hi[tlv_pkg::SRC_TMR1] = irq_level[3];
    src_hi[tlv_pkg::SRC_UART] = irq_level[4];
    src_hi[tlv_pkg::SRC_TMR2] = irq_level[5];
    src_hi[tlv_pkg::SRC_CONV] = irq_level[6];
    src_hi[tlv_pkg::SRC_WDOG] = 1'b1;
  end

  // Eligibility per source; flags are never consumed by masking
  // Disabled flags stay pending
  genvar gi;
  generate
    for (gi = 0; gi < tlv_pkg::NUM_SRC; gi++)
    begin : g_elig
      assign elig_hi[gi] = src_req[gi] & src_en[gi] & src_hi[gi];
      assign elig_lo[gi] = src_req[gi] & src_en[gi] & ~src_hi[gi];
    end
  endgenerate

  // Priority pick: high level wins, then polling order
  always_comb
  begin
    pick_valid = 1'b0;
    pick_hi = 1'b0;
    pick_addr = 16'h0000;
    for (int i = tlv_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (elig_lo[i] & ~act_hi & ~act_lo)
      begin
        pick_addr = tlv_pkg::VEC_TABLE[i];
        pick_valid = 1'b1;
      end
    end
    for (int i = tlv_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (elig_hi[i] & ~act_hi)
      begin
        pick_addr = tlv_pkg::VEC_TABLE[i];
        pick_valid = 1'b1;
        pick_hi = 1'b1;
      end
    end
  end

  // Offer state machine toward the core
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= tlv_pkg::ST_IDLE;
      vec_o <= '0;
    end
    else
    begin
      case (state)
        tlv_pkg::ST_IDLE:
        begin
          if (boundary_i & pick_valid)
          begin
            vec_o <= '{req: 1'b1, hi: pick_hi, addr: pick_addr};
            state <= tlv_pkg::ST_OFFER;
          end
        end
        tlv_pkg::ST_OFFER:
        begin
          // Held until the core has pushed its counter
          // Acceptance on the same edge as the push
          if (vec_ack_i)
          begin
            vec_o.req <= 1'b0;
            state <= tlv_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state <= tlv_pkg::ST_IDLE;
          vec_o <= '0;
        end
      endcase
    end
  end

  // Active level tracking; return ends the innermost level
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      act_hi <= 1'b0;
      act_lo <= 1'b0;
    end
    else
    begin
      if (take & vec_o.hi)
      begin
        act_hi <= 1'b1;
      end
      else if (take)
      begin
        act_lo <= 1'b1;
      end
      else if (reti_i & act_hi)
      begin
        act_hi <= 1'b0;
      end
      else if (reti_i)
      begin
        act_lo <= 1'b0;
      end
    end
  end

  assign wdog_ev = wdog_timeout_i & (wdog_tmo != '0);

  // Watchdog flag or reset pulse
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wdog_flag <= 1'b0;
      wdog_rst_o <= 1'b0;
    end
    else
    begin
      wdog_rst_o <= wdog_ev & ~wdog_irq_mode;
      // Timeout with nonzero wdog_tmo raises flag in irq mode
      if (wdog_ev & wdog_irq_mode)
      begin
        wdog_flag <= 1'b1;
      end
      // Set beats a same-cycle one-to-clear
      else if (wr_go & (paddr_i == tlv_pkg::ADDR_WDOG) & pwdata_i[tlv_pkg::WDOG_FLAG_BIT])
      begin
        wdog_flag <= 1'b0;
      end
    end
  end

  // Configuration registers, written at the completing edge
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      irq_en_reg <= tlv_pkg::RST_IRQ_EN;
      aux_irq_en_lvl <= tlv_pkg::RST_AUX;
      irq_level <= tlv_pkg::RST_LEVEL;
      ev_mask <= '0;
      wdog_irq_mode <= 1'b0;
      wdog_tmo <= '0;
    end
    else if (wr_go)
    begin
      if (paddr_i == tlv_pkg::ADDR_IRQ_EN)
      begin
        irq_en_reg <= pwdata_i[7:0];
      end
      else if (paddr_i == tlv_pkg::ADDR_AUX)
      begin
        aux_irq_en_lvl <= (pwdata_i[7:0] & tlv_pkg::AUX_WMASK) | (tlv_pkg::RST_AUX & ~tlv_pkg::AUX_WMASK);
      end
      else if (paddr_i == tlv_pkg::ADDR_LEVEL)
      begin
        irq_level <= pwdata_i[7:0] & tlv_pkg::LEVEL_WMASK;
      end
      else if (paddr_i == tlv_pkg::ADDR_MASK)
      begin
        ev_mask <= pwdata_i[tlv_pkg::NUM_EV-1:0];
      end
      else if (paddr_i == tlv_pkg::ADDR_WDOG)
      begin
        wdog_irq_mode <= pwdata_i[tlv_pkg::WDOG_MODE_BIT];
        wdog_tmo <= pwdata_i[tlv_pkg::WDOG_TMO_LSB +: TMO_W];
      end
    end
  end

  // Sticky event bits, one written to clear, set wins
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ev_stat <= '0;
    end
    else
    begin
      for (int i = 0; i < tlv_pkg::NUM_EV; i++)
      begin
        if (wr_go & (paddr_i == tlv_pkg::ADDR_STAT) & pwdata_i[i])
        begin
          ev_stat[i] <= 1'b0;
        end
      end
      if (take)
      begin
        ev_stat[tlv_pkg::EV_TAKEN] <= 1'b1;
      end
      if (take & vec_o.hi & act_lo)
      begin
        ev_stat[tlv_pkg::EV_PREEMPT] <= 1'b1;
      end
      if (wdog_ev)
      begin
        ev_stat[tlv_pkg::EV_WDOG] <= 1'b1;
      end
    end
  end

  // Interrupt line from the registered status and mask
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(ev_stat & ev_mask);
    end
  end

  // Read decode; unmapped addresses answer with an error
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr_i == tlv_pkg::ADDR_IRQ_EN)
    begin
      rd_val[7:0] = irq_en_reg;
    end
    else if (paddr_i == tlv_pkg::ADDR_AUX)
    begin
      rd_val[7:0] = aux_irq_en_lvl;
    end
    else if (paddr_i == tlv_pkg::ADDR_LEVEL)
    begin
      rd_val[7:0] = irq_level;
    end
    else if (paddr_i == tlv_pkg::ADDR_STAT)
    begin
      rd_val[tlv_pkg::NUM_EV-1:0] = ev_stat;
    end
    else if (paddr_i == tlv_pkg::ADDR_MASK)
    begin
      rd_val[tlv_pkg::NUM_EV-1:0] = ev_mask;
    end
    else if (paddr_i == tlv_pkg::ADDR_WDOG)
    begin
      rd_val[tlv_pkg::WDOG_MODE_BIT] = wdog_irq_mode;
      rd_val[tlv_pkg::WDOG_TMO_LSB +: TMO_W] = wdog_tmo;
      rd_val[tlv_pkg::WDOG_FLAG_BIT] = wdog_flag;
    end
    else if (paddr_i == tlv_pkg::ADDR_CORE)
    begin
      // Live arbiter view for software
      rd_val[0] = act_lo;
      rd_val[1] = act_hi;
      rd_val[2] = vec_o.req;
      rd_val[31:16] = vec_o.addr;
    end
    else
    begin
      rd_err = 1'b1;
    end
  end

  // APB answer: one wait cycle so outputs stay registered
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (rd_go)
    begin
      pready_o <= 1'b1;
      prdata_o <= pwrite_i ? 32'h0000_0000 : rd_val;
      pslverr_o <= rd_err;
    end
    else
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

endmodule : tlv_irq_ctrl

// File: src/tlv_pkg.sv
// Purpose: Shared constants and types of the two-level interrupt controller.
// Assumes: APB slave with 32-bit data, register index times four as byte address.
// Notes: Source index order equals the fixed polling order, 0 polls first.
package tlv_pkg;
  // Register indices and their byte addresses
  localparam logic [7:0] IDX_IRQ_EN = 8'ha8;
  localparam logic [7:0] IDX_AUX = 8'ha9;
  localparam logic [7:0] IDX_LEVEL = 8'hb8;
  localparam logic [7:0] IDX_STAT = 8'hc0;
  localparam logic [7:0] IDX_MASK = 8'hc1;
  localparam logic [7:0] IDX_WDOG = 8'hc2;
  localparam logic [7:0] IDX_CORE = 8'hc3;
  localparam logic [11:0] ADDR_IRQ_EN = {2'h0, IDX_IRQ_EN, 2'h0};
  localparam logic [11:0] ADDR_AUX = {2'h0, IDX_AUX, 2'h0};
  localparam logic [11:0] ADDR_LEVEL = {2'h0, IDX_LEVEL, 2'h0};
  localparam logic [11:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
  localparam logic [11:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};
  localparam logic [11:0] ADDR_WDOG = {2'h0, IDX_WDOG, 2'h0};
  localparam logic [11:0] ADDR_CORE = {2'h0, IDX_CORE, 2'h0};
  // Reset values
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_AUX = 8'ha0;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  // Field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int AUX_RSVD_BIT = 3;
  localparam int AUX_TOP_BIT = 7;
  localparam int WDOG_MODE_BIT = 0;
  localparam int WDOG_FLAG_BIT = 8;
  localparam int WDOG_TMO_LSB = 4;
  localparam logic [7:0] AUX_WMASK = 8'h77;
  localparam logic [7:0] LEVEL_WMASK = 8'h7f;
  // Status events: vector taken, watchdog event, preemption
  localparam int NUM_EV = 3;
  localparam int EV_TAKEN = 0;
  localparam int EV_WDOG = 1;
  localparam int EV_PREEMPT = 2;
  // Sources in polling order
  localparam int NUM_SRC = 11;
  localparam int SRC_SUPPLY = 0;
  localparam int SRC_WDOG = 1;
  localparam int SRC_EXT0 = 2;
  localparam int SRC_CONV = 3;
  localparam int SRC_TMR0 = 4;
  localparam int SRC_EXT1 = 5;
  localparam int SRC_TMR1 = 6;
  localparam int SRC_SYNC = 7;
  localparam int SRC_UART = 8;
  localparam int SRC_TMR2 = 9;
  localparam int SRC_ICTR = 10;
  // Vector table in polling order
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
    16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
  // Arbiter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OFFER = 2'b10
  } tlv_state_t;
  // Vector offered to the core
  typedef struct packed {
    logic req;
    logic hi;
    logic [15:0] addr;
  } tlv_vec_t;
endpackage : tlv_pkg

// File: verification/tlv_irq_ctrl_assertions.sv
// Purpose: Port checks of the interrupt controller
// Assumes: One clock domain, async high reset
// Notes: Bound into every controller instance
`timescale 1ns/1ps
module tlv_irq_ctrl_assertions #(
  parameter int TMO_W = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic boundary_i,
  input wire logic vec_ack_i,
  input wire logic wdog_timeout_i,
  input wire logic wdog_rst_o,
  input wire tlv_pkg::tlv_vec_t vec_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Access phase still waiting
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  // Core takes the offer
  sequence s_taken;
    vec_o.req && vec_ack_i;
  endsequence
  property p_one_wait;
    s_access |=> pready_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");
  property p_err_rdy;
    pslverr_o |-> pready_o;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
  property p_hold;
    vec_o.req && !vec_ack_i |=> vec_o.req && $stable(vec_o);
  endproperty
  a_hold: assert property (p_hold) else $error("offer moved");
  property p_drop;
    s_taken |=> !vec_o.req;
  endproperty
  a_drop: assert property (p_drop) else $error("offer kept");
  property p_bnd;
    $rose(vec_o.req) |-> $past(boundary_i);
  endproperty
  a_bnd: assert property (p_bnd) else $error("offer off boundary");
  property p_wd_hi;
    vec_o.req && vec_o.addr == 16'h005b |-> vec_o.hi;
  endproperty
  a_wd_hi: assert property (p_wd_hi) else $error("watchdog not high");
  property p_vec;
    vec_o.req |-> vec_o.addr inside {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
      16'h0033, 16'h003b, 16'h0043, 16'h0053, 16'h005b};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_rst;
    wdog_rst_o |-> $past(wdog_timeout_i);
  endproperty
  a_rst: assert property (p_rst) else $error("reset without timeout");
endmodule : tlv_irq_ctrl_assertions

bind tlv_irq_ctrl tlv_irq_ctrl_assertions #(.TMO_W(TMO_W)) u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .boundary_i(boundary_i), .vec_ack_i(vec_ack_i), .wdog_timeout_i(wdog_timeout_i),
  .wdog_rst_o(wdog_rst_o), .vec_o(vec_o));

// File: verification/tlv_core_model.sv
// Purpose: Core sequencer that takes offered vectors
// Assumes: Ack comes one cycle after an offer
// Notes: Hold stops boundaries and acks, a slow core
`timescale 1ns/1ps
module tlv_core_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic hold_i,
  input wire tlv_pkg::tlv_vec_t vec_i,
  output logic boundary_o,
  output logic ack_o,
  output logic [16:0] last_o,
  output logic [7:0] cnt_o
);
  logic [15:0] pc; // Program counter
  logic [15:0] stk; // One-deep stack
  assign boundary_o = !hold_i;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ack_o <= 1'b0;
      last_o <= '0;
      cnt_o <= '0;
      pc <= '0;
      stk <= '0;
    end
    else
    begin
      ack_o <= vec_i.req && !ack_o && !hold_i;
      pc <= pc + 16'h1;
      // Taken edge: save pc and jump
      if (ack_o && vec_i.req)
      begin
        stk <= pc;
        pc <= vec_i.addr;
        last_o <= {vec_i.hi, vec_i.addr};
        cnt_o <= cnt_o + 8'h1;
      end
    end
  end
endmodule : tlv_core_model

// File: verification/tb.sv
// Purpose: Self-checking bench of the interrupt controller
// Assumes: APB master and core model on one clock
// Notes: Flags are levels; the bench lowers each after service
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0;
  logic [31:0] prd;
  logic [31:0] rd;
  logic rdy;
  logic err;
  logic re;
  logic [10:0] fl = '0; // Sources in polling order
  logic alt = 1'b0; // Picks one flag of a shared pair
  logic tto = 1'b0;
  logic reti = 1'b0;
  logic hold = 1'b0;
  logic bnd;
  logic ack;
  logic irq;
  logic wrst;
  logic [16:0] last;
  logic [7:0] cnt;
  tlv_pkg::tlv_vec_t vec;
  int failures = 0;
  int cmp_count = 0;
  // Core clock
  always #2 clk_i = ~clk_i;
  tlv_irq_ctrl u_tlv_irq_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
    .supply_mon_flag_i(fl[0]), .ext0_flag_i(fl[2]), .conv_done_flags_i({fl[3] & alt, fl[3] & ~alt}),
    .tmr0_ovf_flag_i(fl[4]), .ext1_flag_i(fl[5]), .tmr1_ovf_flag_i(fl[6]), .twowire_flag_i(fl[7] & alt),
    .sync_port_flag_i(fl[7] & ~alt), .uart_rx_flag_i(fl[8] & ~alt), .uart_tx_flag_i(fl[8] & alt),
    .tmr2_ovf_flag_i(fl[9] & ~alt), .tmr2_ext_flag_i(fl[9] & alt), .interval_ctr_flag_i(fl[10]),
    .wdog_timeout_i(tto), .boundary_i(bnd), .vec_ack_i(ack), .reti_i(reti), .vec_o(vec),
    .wdog_rst_o(wrst), .irq_o(irq));
  tlv_core_model u_tlv_core_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hold_i(hold), .vec_i(vec),
    .boundary_o(bnd), .ack_o(ack), .last_o(last), .cnt_o(cnt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    // No cycle count assumed; only the hang guard ends this wait
    do
    begin
      @(posedge clk_i);
    end
    while (rdy !== 1'b1);
    rd = prd;
    re = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic fs(input logic [10:0] v);
    @(posedge clk_i);
    fl <= v;
  endtask : fs
  task automatic rt();
    @(posedge clk_i);
    reti <= 1'b1;
    @(posedge clk_i);
    reti <= 1'b0;
  endtask : rt
  // Waits for the next taken vector
  task automatic wvec(input logic [16:0] e);
    logic [7:0] c0;
    int n;
    c0 = cnt;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (cnt === c0 && n < 60);
    // A vector that never came counts as a mismatch
    if (cnt === c0)
      chk(cnt, c0 + 8'h1);
    chk(last, e);
  endtask : wvec
  task automatic nov(input int n);
    logic [7:0] c0;
    c0 = cnt;
    repeat (n) @(posedge clk_i);
    chk(cnt, c0);
  endtask : nov
  task automatic pulse();
    @(posedge clk_i);
    tto <= 1'b1;
    @(posedge clk_i);
    tto <= 1'b0;
    #1;
  endtask : pulse
  task automatic t_regs();
    rdc(tlv_pkg::ADDR_IRQ_EN, 32'h0);
    rdc(tlv_pkg::ADDR_AUX, 32'ha0);
    rdc(tlv_pkg::ADDR_LEVEL, 32'h0);
    wr(tlv_pkg::ADDR_AUX, 32'h77);
    rdc(tlv_pkg::ADDR_AUX, 32'hf7);
    wr(tlv_pkg::ADDR_LEVEL, 32'hff);
    rdc(tlv_pkg::ADDR_LEVEL, 32'h7f);
    rdc(12'h000, 32'h0);
    chk(re, 1'b1);
    $display("t_regs done");
  endtask : t_regs
  // All low; pending set shrinks one source at a time
  task automatic t_poll();
    wr(tlv_pkg::ADDR_LEVEL, 32'h0);
    wr(tlv_pkg::ADDR_IRQ_EN, 32'hff);
    wr(tlv_pkg::ADDR_AUX, 32'h07);
    for (int i = 0; i < 11; i++)
    begin
      if (i != tlv_pkg::SRC_WDOG)
      begin
        @(posedge clk_i);
        alt <= i[0];
        fl <= (11'h7ff << i) & 11'h7fd;
        wvec({1'b0, tlv_pkg::VEC_TABLE[i]});
        fl <= '0;
        rt();
      end
    end
    $display("t_poll done");
  endtask : t_poll
  task automatic t_prio();
    wr(tlv_pkg::ADDR_LEVEL, 32'h21);
    fs(11'h240);
    wvec({1'b1, 16'h002b});
    nov(20);
    fs(11'h040);
    rt();
    wvec({1'b0, 16'h001b});
    fs(11'h044);
    wvec({1'b1, 16'h0003});
    rdc(tlv_pkg::ADDR_CORE, 32'h0003_0003);
    fs(11'h244);
    nov(20);
    fs(11'h240);
    rt();
    wvec({1'b1, 16'h002b});
    fs(11'h0);
    rt();
    rt();
    $display("t_prio done");
  endtask : t_prio
  task automatic t_mask();
    wr(tlv_pkg::ADDR_LEVEL, 32'h0);
    wr(tlv_pkg::ADDR_AUX, 32'h0);
    wr(tlv_pkg::ADDR_IRQ_EN, 32'h80);
    fs(11'h400);
    nov(20);
    wr(tlv_pkg::ADDR_AUX, 32'h04);
    wvec({1'b0, 16'h0053});
    fs(11'h0);
    rt();
    wr(tlv_pkg::ADDR_IRQ_EN, 32'h01);
    fs(11'h004);
    nov(20);
    hold <= 1'b1;
    wr(tlv_pkg::ADDR_IRQ_EN, 32'h81);
    nov(20);
    hold <= 1'b0;
    wvec({1'b0, 16'h0003});
    fs(11'h0);
    rt();
    $display("t_mask done");
  endtask : t_mask
  task automatic t_wdog();
    wr(tlv_pkg::ADDR_IRQ_EN, 32'h0);
    wr(tlv_pkg::ADDR_WDOG, 32'h001);
    pulse();
    nov(20);
    rdc(tlv_pkg::ADDR_WDOG, 32'h001);
    wr(tlv_pkg::ADDR_WDOG, 32'h031);
    pulse();
    wvec({1'b1, 16'h005b});
    rdc(tlv_pkg::ADDR_WDOG, 32'h131);
    wr(tlv_pkg::ADDR_WDOG, 32'h130);
    rt();
    rdc(tlv_pkg::ADDR_WDOG, 32'h030);
    pulse();
    chk(wrst, 1'b1);
    $display("t_wdog done");
  endtask : t_wdog
  task automatic t_irq();
    rdc(tlv_pkg::ADDR_STAT, 32'h7);
    wr(tlv_pkg::ADDR_MASK, 32'h4);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    wr(tlv_pkg::ADDR_STAT, 32'h7);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    rdc(tlv_pkg::ADDR_STAT, 32'h0);
    $display("t_irq done");
  endtask : t_irq
  task automatic summarize();
    $display("checks=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Hang guard, far above the expected run
  initial
  begin
    #200000;
    failures++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_poll();
    t_prio();
    t_mask();
    t_wdog();
    t_irq();
    summarize();
  end
endmodule : tb
